// ===== msp_consts.vh
`ifndef MSP_CONSTS_VH
`define MSP_CONSTS_VH
// Mode field codes
`define MSP_MODE_M4 4'h0
`define MSP_MODE_M16 4'h1
`define MSP_MODE_M64 4'h2
`define MSP_MODE_MTMR 4'h3
`define MSP_MODE_SSEL 4'h4
`define MSP_MODE_SFREE 4'h5
`define MSP_MODE_MRLD 4'ha
// System clock cycles per serial half period for the fixed dividers
`define MSP_HALF_4 8'h02
`define MSP_HALF_16 8'h08
`define MSP_HALF_64 8'h20
// Bits per byte
`define MSP_BITS 4'h8
`endif

// ===== msp_port.v
`timescale 1ns/10ps
`include "msp_consts.vh"
// Notes on behaviour
// - Master starts whenever it likes
// - Master buffer write starts eight-bit exchange
// - Receive-only master still shifts and loads
// - Idle polarity selectable, launch edge selectable in slave only, MSB first
// - Master rate: /4,/16,/64, timer/2, reload
// - Launch-first mode: data valid before first edge
// - Slave shifts on external clock, flags last bit
// - Slave detects pin clock edges on the system clock
// - Slave resends the byte previously received
// - Overwrite enable allows writes over unread byte
// - Mode 0100 selects framed slave
// - Select low: shift and drive output
// - Select high: output released at once
// - Select high resets port logic
// - Any port reset zeroes bit counter
// - Master sample phase: middle or end of bit
// - Write while busy dropped, collision flag set
// - Loaded byte sets full flag; read clears
// - Port active only while enabled
module msp_port (
  // Clock and reset
  input wire clock_i,
  input wire reset_i,
  // Configuration
  input wire port_enable_i,
  input wire [3:0] mode_i,
  input wire clock_idle_polarity_i,
  input wire clock_edge_i,
  input wire input_sample_phase_i,
  input wire buffer_overwrite_enable_i,
  input wire [7:0] rate_reload_i,
  input wire period_timer_i,
  // Software buffer access
  input wire data_buffer_write_i,
  input wire [7:0] data_buffer_wdata_i,
  input wire data_buffer_read_i,
  output wire [7:0] data_buffer_o,
  input wire write_collision_clear_i,
  input wire transfer_done_clear_i,
  // Status
  output wire buffer_full_flag_o,
  output wire write_collision_flag_o,
  output wire transfer_done_flag_o,
  output wire busy_o,
  // Serial pins
  input wire serial_clock_pin_i,
  output wire serial_clock_pin_o,
  output wire serial_clock_pin_oe_n_o,
  input wire serial_in_pin_i,
  output wire serial_out_pin_o,
  output wire serial_out_pin_oe_n_o,
  input wire slave_select_n_i
);
  // How the port is built
  // Every pin input crosses into the system clock through two flops, so the
  // serial clock, serial input, select and timer pins are seen two clocks late; only the output enable takes select at once.
  // The master counts half periods of the serial clock and toggles its own
  // clock output; its receive path waits those two clocks after each sample
  // point before it takes the bit, so fast rates still read the right bit.
  // The slave detects pin clock edges in the system domain, which limits the
  // pin clock to well below a quarter of the system clock.
  // Flags are set by hardware and cleared by pulses; a set in the same cycle
  // as a clear wins, so no event is ever lost.

  // Synchronisers for pin inputs
  reg [1:0] sck_sync_reg;
  reg [1:0] sdi_sync_reg;
  reg [1:0] ss_sync_reg;
  reg [1:0] tmr_sync_reg;
  reg sck_prev_reg;
  reg tmr_prev_reg;
  always @(posedge clock_i) begin
    if (reset_i) begin
      // Clock history starts at the idle level, so no false edge follows reset
      sck_sync_reg <= {2{clock_idle_polarity_i}};
      sdi_sync_reg <= 2'h0;
      ss_sync_reg <= 2'h3;
      tmr_sync_reg <= 2'h0;
      sck_prev_reg <= clock_idle_polarity_i;
      tmr_prev_reg <= 1'b0;
    end else begin
      sck_sync_reg <= {sck_sync_reg[0], serial_clock_pin_i};
      sdi_sync_reg <= {sdi_sync_reg[0], serial_in_pin_i};
      ss_sync_reg <= {ss_sync_reg[0], slave_select_n_i};
      tmr_sync_reg <= {tmr_sync_reg[0], period_timer_i};
      sck_prev_reg <= sck_sync_reg[1];
      tmr_prev_reg <= tmr_sync_reg[1];
    end
  end

  // Mode decode
  wire is_master = (mode_i == `MSP_MODE_M4) || (mode_i == `MSP_MODE_M16) || (mode_i == `MSP_MODE_M64) ||
                   (mode_i == `MSP_MODE_MTMR) || (mode_i == `MSP_MODE_MRLD);
  wire is_framed = (mode_i == `MSP_MODE_SSEL);
  wire is_slave = is_framed || (mode_i == `MSP_MODE_SFREE);
  wire ss_high = ss_sync_reg[1];
  // Port held in reset while disabled or while a framed slave is deselected
  wire port_clear = !port_enable_i || (is_framed && ss_high);

  // Slave clock edges in the system domain; the shifter sees the pin clock
  // through two flops, so the pin clock must be well below a quarter of clock_i
  wire sck_rise = sck_sync_reg[1] && !sck_prev_reg;
  wire sck_fall = !sck_sync_reg[1] && sck_prev_reg;
  wire tmr_rise = tmr_sync_reg[1] && !tmr_prev_reg;

  // Core state
  reg [7:0] shift_reg;
  reg [7:0] buf_reg;
  reg [3:0] count_reg;
  reg active_reg;
  reg sck_out_reg;
  reg sdo_reg;
  // Master receive side: captured bits, capture and finish delay lines
  reg [7:0] rx_reg;
  reg [1:0] cap_pipe_reg;
  reg [1:0] fin_pipe_reg;
  // Set once the eighth trailing edge is out; the clock is parked then
  reg tx_end_reg;
  reg [8:0] div_reg;
  reg full_reg;
  reg write_collision_flag_reg;
  reg done_reg;

  // Master half-period length in system clocks
  function [8:0] half_len;
    input [3:0] mode;
    input [7:0] reload;
    begin
      case (mode)
        `MSP_MODE_M4: half_len = {1'b0, `MSP_HALF_4};
        `MSP_MODE_M16: half_len = {1'b0, `MSP_HALF_16};
        `MSP_MODE_M64: half_len = {1'b0, `MSP_HALF_64};
        `MSP_MODE_MRLD: half_len = {reload, 1'b0} + 9'h002;
        default: half_len = 9'h001;
      endcase
    end
  endfunction

  // Master tick: end of a half period, or each timer rising edge
  wire [8:0] half_now = half_len(mode_i, rate_reload_i);
  wire m_tick = (mode_i == `MSP_MODE_MTMR) ? tmr_rise : (div_reg + 9'h001 >= half_now);

  // Leading and trailing edges of the serial clock for the selected mode
  wire lead_edge = clock_idle_polarity_i ? sck_fall : sck_rise;
  wire trail_edge = clock_idle_polarity_i ? sck_rise : sck_fall;
  // Launch-first mode shifts on the leading edge, otherwise on the trailing
  wire s_sample = clock_edge_i ? lead_edge : trail_edge;
  wire s_launch = clock_edge_i ? trail_edge : lead_edge;
  wire slave_go = is_slave && !(is_framed && ss_high);

  // Write accepted only when idle and (empty, overwrite allowed or slave), and collision clear
  wire write_ok = !active_reg && !write_collision_flag_reg && (!full_reg || buffer_overwrite_enable_i || is_slave);
  wire write_coll = data_buffer_write_i && active_reg;
  wire last_bit = (count_reg == `MSP_BITS - 4'h1);

  // Master sample point: leading edge for the middle, trailing for the end.
  // The bit is taken two clocks later, when the synchroniser shows the level
  // that stood on the pin at that edge; the half period is never shorter, except with a reload of 0xff, where the length wraps to zero.
  wire lead_now = (sck_out_reg == clock_idle_polarity_i);
  wire m_step = is_master && active_reg && !tx_end_reg && m_tick;
  wire cap_now = m_step && (lead_now ? !input_sample_phase_i : input_sample_phase_i);
  wire fin_now = m_step && !lead_now && last_bit;
  // Received byte including a bit that lands in this very cycle
  wire [7:0] rx_now = cap_pipe_reg[1] ? {rx_reg[6:0], sdi_sync_reg[1]} : rx_reg;

  // Main sequencer
  always @(posedge clock_i) begin
    if (reset_i) begin
      shift_reg <= 8'h00;
      buf_reg <= 8'h00;
      count_reg <= 4'h0;
      active_reg <= 1'b0;
      sck_out_reg <= 1'b0;
      sdo_reg <= 1'b0;
      rx_reg <= 8'h00;
      cap_pipe_reg <= 2'h0;
      fin_pipe_reg <= 2'h0;
      tx_end_reg <= 1'b0;
      div_reg <= 9'h000;
      full_reg <= 1'b0;
      write_collision_flag_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      // Delay lines run every clock; a port clear below overrides them
      cap_pipe_reg <= {cap_pipe_reg[0], cap_now};
      fin_pipe_reg <= {fin_pipe_reg[0], fin_now};
      // Flags: hardware set wins over software clear
      if (write_coll) begin
        write_collision_flag_reg <= 1'b1;
      end else if (write_collision_clear_i) begin
        write_collision_flag_reg <= 1'b0;
      end
      if (data_buffer_read_i) begin
        full_reg <= 1'b0;
      end
      if (transfer_done_clear_i) begin
        done_reg <= 1'b0;
      end
      if (port_clear) begin
        count_reg <= 4'h0;
        active_reg <= 1'b0;
        div_reg <= 9'h000;
        cap_pipe_reg <= 2'h0;
        fin_pipe_reg <= 2'h0;
        tx_end_reg <= 1'b0;
        sck_out_reg <= clock_idle_polarity_i;
      end else if (is_master) begin
        if (!active_reg) begin
          sck_out_reg <= clock_idle_polarity_i;
          div_reg <= 9'h000;
          if (data_buffer_write_i && write_ok) begin
            // Start at once, first bit already on the line
            shift_reg <= data_buffer_wdata_i;
            buf_reg <= data_buffer_wdata_i;
            sdo_reg <= data_buffer_wdata_i[7];
            active_reg <= 1'b1;
            count_reg <= 4'h0;
          end
        end else begin
          // Receive keeps going even with the output unused
          if (cap_pipe_reg[1]) begin
            rx_reg <= rx_now;
          end
          // Two clocks after the last trailing edge every bit is in
          if (fin_pipe_reg[1]) begin
            buf_reg <= rx_now;
            full_reg <= 1'b1;
            done_reg <= 1'b1;
            active_reg <= 1'b0;
            tx_end_reg <= 1'b0;
          end
          if (tx_end_reg) begin
            // Clock stays at idle while the last sample drains
            div_reg <= 9'h000;
          end else if (m_tick) begin
            div_reg <= 9'h000;
            if (lead_now) begin
              // Leading edge: data already stands on the line
              sck_out_reg <= !clock_idle_polarity_i;
            end else begin
              // Trailing edge: launch the next bit, MSB first
              sck_out_reg <= clock_idle_polarity_i;
              shift_reg <= {shift_reg[6:0], 1'b0};
              sdo_reg <= shift_reg[6];
              if (last_bit) begin
                tx_end_reg <= 1'b1;
                count_reg <= 4'h0;
              end else begin
                count_reg <= count_reg + 4'h1;
              end
            end
          end else begin
            div_reg <= div_reg + 9'h001;
          end
        end
      end else if (slave_go) begin
        // Slave: byte in shift register goes out on the next frame
        if (data_buffer_write_i && write_ok && count_reg == 4'h0) begin
          shift_reg <= data_buffer_wdata_i;
          buf_reg <= data_buffer_wdata_i;
          sdo_reg <= data_buffer_wdata_i[7];
        end else if (s_sample) begin
          // Select and pin clock drive the shifter; no system event needed
          active_reg <= 1'b1;
          shift_reg <= {shift_reg[6:0], sdi_sync_reg[1]};
          if (last_bit) begin
            buf_reg <= {shift_reg[6:0], sdi_sync_reg[1]};
            full_reg <= 1'b1;
            done_reg <= 1'b1;
            active_reg <= 1'b0;
            count_reg <= 4'h0;
            sdo_reg <= shift_reg[6]; // Received byte's MSB leads the next frame
          end else begin
            count_reg <= count_reg + 4'h1;
          end
        end else if (s_launch && active_reg) begin
          sdo_reg <= shift_reg[7];
        end
      end
    end
  end

  // Outputs
  assign data_buffer_o = buf_reg;
  assign buffer_full_flag_o = full_reg;
  assign write_collision_flag_o = write_collision_flag_reg;
  assign transfer_done_flag_o = done_reg;
  assign busy_o = active_reg;
  assign serial_clock_pin_o = sck_out_reg;
  assign serial_clock_pin_oe_n_o = !(port_enable_i && is_master); // Slave leaves the clock to the master
  assign serial_out_pin_o = sdo_reg;
  // Released at once when the framed slave is deselected
  assign serial_out_pin_oe_n_o = !(port_enable_i && (is_master || (is_slave && !(is_framed && slave_select_n_i))));
endmodule

// ===== msp_port_sva.sv
`timescale 1ns/10ps
module msp_port_chk (
  // Controls
  input wire clock_i,
  input wire reset_i,
  input wire port_enable_i,
  input wire [3:0] mode_i,
  input wire clock_idle_polarity_i,
  input wire clock_edge_i,
  input wire data_buffer_write_i,
  input wire data_buffer_read_i,
  input wire slave_select_n_i,
  // Outputs watched
  input wire buffer_full_flag_o,
  input wire write_collision_flag_o,
  input wire transfer_done_flag_o,
  input wire busy_o,
  input wire serial_clock_pin_o,
  input wire serial_clock_pin_oe_n_o,
  input wire serial_out_pin_o,
  input wire serial_out_pin_oe_n_o
);
  // One domain, so clock and disable are given once
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  a_write_starts: assert property (port_enable_i && mode_i == 4'h0 && data_buffer_write_i && !busy_o
    && !write_collision_flag_o && !buffer_full_flag_o |=> busy_o) else $error("write did not start");
  a_byte_length: assert property ($rose(busy_o) && mode_i == 4'h0 |-> ##30 busy_o ##[1:4] !busy_o)
    else $error("byte length off");
  a_clock_idle: assert property (port_enable_i && mode_i == 4'h0 && !busy_o
    |-> serial_clock_pin_o == clock_idle_polarity_i) else $error("clock not idle");
  a_clock_driven: assert property (busy_o && mode_i == 4'h0 |-> !serial_clock_pin_oe_n_o)
    else $error("clock not driven");
  a_launch_edge: assert property (busy_o && mode_i == 4'h0 && clock_edge_i && !clock_idle_polarity_i
    && $changed(serial_out_pin_o) |-> !serial_clock_pin_o) else $error("data moved on wrong edge");
  a_collision_set: assert property (data_buffer_write_i && busy_o |=> write_collision_flag_o)
    else $error("collision not flagged");
  a_done_flags: assert property (port_enable_i && mode_i == 4'h0 && $fell(busy_o)
    |-> transfer_done_flag_o && buffer_full_flag_o) else $error("end flags missing");
  a_read_clears: assert property (data_buffer_read_i && !busy_o |=> !buffer_full_flag_o)
    else $error("full flag kept");
  a_select_release: assert property (mode_i == 4'h4 && slave_select_n_i |-> serial_out_pin_oe_n_o)
    else $error("output still driven");
endmodule
bind msp_port msp_port_chk i_chk (.*);

// ===== msp_slave_model.sv
`timescale 1ns/10ps
module msp_slave_model (
  // Serial side
  input wire sclk_i,
  input wire mosi_i,
  output wire miso_o,
  // Test side
  input wire load_i,
  input wire [7:0] tx_i,
  output reg [7:0] rx_o
);
  reg [7:0] sh_reg;
  assign miso_o = sh_reg[7]; // Bit 7 leads
  // Load presents bit 7 before the first clock edge
  always @(posedge load_i) sh_reg <= tx_i;
  // Launch on falling edge; refill with a moving pattern so stale data never matches
  always @(negedge sclk_i) sh_reg <= {sh_reg[6:0], ~sh_reg[0]};
  // Sample on rising edge
  always @(posedge sclk_i) rx_o <= {rx_o[6:0], mosi_i};
endmodule

// ===== msp_port_tb_top.sv
`timescale 1ns/10ps
module msp_port_tb_top;
  reg clock_i = 1'b0;
  reg reset_i = 1'b1;
  reg en = 0, wr = 0, rd = 0, wcc = 0, dnc = 0, tmr = 0, pld = 0, slv = 0, sck = 0, sdi = 0, ssn = 1, input_sample_phase = 0;
  reg [3:0] mode = 4'h0;
  reg [7:0] wdat = 8'h00, rr = 8'h00, ptx = 8'h00;
  reg [31:0] r;
  integer err_total = 0, check_count = 0, k, seed;
  wire [7:0] dbo, prx;
  wire full, write_collision_flag, done, busy, sclk_o, sdo, miso, oe_n, sck_oe_n;
  msp_port i_dut (.clock_i(clock_i), .reset_i(reset_i), .port_enable_i(en), .mode_i(mode),
    .clock_idle_polarity_i(1'b0), .clock_edge_i(1'b1), .input_sample_phase_i(input_sample_phase),
    .buffer_overwrite_enable_i(1'b0), .rate_reload_i(rr), .period_timer_i(tmr), .data_buffer_write_i(wr),
    .data_buffer_wdata_i(wdat), .data_buffer_read_i(rd), .data_buffer_o(dbo), .write_collision_clear_i(wcc),
    .transfer_done_clear_i(dnc), .buffer_full_flag_o(full), .write_collision_flag_o(write_collision_flag),
    .transfer_done_flag_o(done), .busy_o(busy), .serial_clock_pin_i(slv ? sck : sclk_o),
    .serial_clock_pin_o(sclk_o), .serial_clock_pin_oe_n_o(sck_oe_n), .serial_in_pin_i(slv ? sdi : miso),
    .serial_out_pin_o(sdo), .serial_out_pin_oe_n_o(oe_n), .slave_select_n_i(ssn));
  msp_slave_model i_far (.sclk_i(sclk_o), .mosi_i(sdo), .miso_o(miso), .load_i(pld), .tx_i(ptx), .rx_o(prx));
  // Clock and an unrelated timer source
  always #50 clock_i = ~clock_i;
  always #730 tmr = ~tmr;
  task chk(input [7:0] g, input [7:0] e);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task print_verdict;
    begin
      if (err_total == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task wcyc(input integer n);
    repeat (n) @(negedge clock_i);
  endtask
  // Master byte; write held two cycles so the second edge hits a busy port
  task xfer(input [3:0] m, input [7:0] a, input [7:0] b);
    integer i;
    begin
      mode = m; ptx = b; pld = 1; wdat = a; wcyc(1); pld = 0; wr = 1; wcyc(2); wr = 0;
      chk({7'h0, write_collision_flag}, 8'h01);
      chk({7'h0, sck_oe_n}, 8'h00);
      wcc = 1; wdat = ~a; wcyc(1); wcc = 0;
      chk({7'h0, write_collision_flag}, 8'h00);
      i = 0;
      while (busy !== 1'b0 && i < 2000) begin wcyc(1); i = i + 1; end
      if (i == 2000) begin err_total = err_total + 1; print_verdict; end
      wcyc(2);
      chk(dbo, b);
      chk(prx, a);
      chk({6'h0, full, done}, 8'h03);
      rd = 1; dnc = 1; wcyc(1); rd = 0; dnc = 0;
      chk({6'h0, full, done}, 8'h00);
    end
  endtask
  // Slave bits from the test side, n bits of v, slow pin clock
  task sbits(input [7:0] v, input integer n);
    integer i;
    for (i = 0; i < n; i = i + 1) begin
      sdi = v[7 - i]; wcyc(8); sck = 1; wcyc(8); sck = 0;
    end
  endtask
  initial begin
    seed = $urandom(32'h62cf8d79);
    wcyc(5); reset_i = 0; en = 1;
    xfer(4'h0, 8'h00, 8'hff);
    xfer(4'h0, 8'hff, 8'h00);
    for (k = 0; k < 10; k = k + 1) begin
      r = $urandom; rr = {5'h0, r[18:16]}; input_sample_phase = r[19];
      xfer(k % 5 == 4 ? 4'ha : k % 5, r[7:0], r[15:8]);
    end
    en = 0; mode = 4'h4; slv = 1; input_sample_phase = 0; wcyc(2); en = 1; wcyc(4);
    chk({7'h0, oe_n}, 8'h01);
    chk({7'h0, sck_oe_n}, 8'h01);
    ssn = 0; wcyc(4);
    chk({7'h0, oe_n}, 8'h00);
    r = $urandom; sbits(r[7:0], 8); wcyc(8);
    chk(dbo, r[7:0]);
    chk({7'h0, done}, 8'h01);
    chk({7'h0, sdo}, {7'h0, r[7]});
    rd = 1; dnc = 1; sbits(8'h5a, 3); rd = 0; dnc = 0; ssn = 1; wcyc(4);
    ssn = 0; wcyc(4); sbits(r[15:8], 8); wcyc(8);
    chk(dbo, r[15:8]);
    print_verdict;
  end
endmodule
